// ---- rtl/cfm_pkg.sv ----
// Constants and types shared by the frequency measurement pair and its FIFO.
// Assumes a single 10 MHz system clock and synchronous active-low reset.
package cfm_pkg;
  localparam int unsigned CNT_W       = 32;     // Width of every count
  localparam int unsigned FIFO_DEPTH  = 8;      // Result FIFO depth in words
  localparam int unsigned RES_W       = 2 * CNT_W + 1; // Count pair plus overflow flag
  localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0000_0000;
  localparam logic [CNT_W-1:0] CNT_ONE  = 32'h0000_0001;
  localparam logic [CNT_W-1:0] CNT_MAX  = 32'hFFFF_FFFF;
  localparam real  CLK_PERIOD_NS  = 100.0;      // System clock period
  localparam real  ARM_SETTLE_NS  = 100.0;      // Least idle time after arming
  localparam int unsigned ARM_SETTLE_CYC =
    (ARM_SETTLE_NS / CLK_PERIOD_NS) < 1.0 ? 1 : int'($ceil(ARM_SETTLE_NS / CLK_PERIOD_NS));

  // Measurement methods
  typedef enum logic [1:0] {
    CFM_HIGH_FREQ,      // Known-width gate, count unknown signal
    CFM_LARGE_RANGE,    // Divide by N, time the long pulse
    CFM_SAMPLE_CLOCKED  // Counts latched at each sample clock
  } cfm_method_e;

  // Sequencer states of the counter pair
  typedef enum logic [1:0] {
    CFM_IDLE,
    CFM_WAIT_START,
    CFM_MEASURE,
    CFM_DONE
  } cfm_state_e;
endpackage

// ---- rtl/cfm_fifo_if.sv ----
// Valid/ready stream between the counter pair and its result FIFO.
// Assumes both ends share sys_clk.
`timescale 1ns/1ps
`default_nettype none
interface cfm_fifo_if #(parameter int unsigned WIDTH = 8);
  logic             valid; // Word offered
  logic             ready; // Word can be taken
  logic [WIDTH-1:0] data;  // Offered word
  modport src (output valid, output data, input ready);
  modport dst (input valid, input data, output ready);
endinterface
`default_nettype wire

// ---- rtl/cfm_fifo.sv ----
// Parameterised result FIFO with valid/ready on both sides.
// Assumes a single clock; reset is synchronous, active low.
`timescale 1ns/1ps
`default_nettype none
module cfm_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  // Fill side
  cfm_fifo_if.dst         wr,
  // Drain side
  output logic            rd_valid,
  input  wire logic       rd_ready,
  output logic [WIDTH-1:0] rd_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];     // Storage array
  logic [AW-1:0]    wptr, next_wptr; // Write index
  logic [AW-1:0]    rptr, next_rptr; // Read index
  logic [AW:0]      fill, next_fill; // Words held
  logic             push, pop;

  // Handshakes and honest full/empty
  assign wr.ready = (fill < (AW+1)'(DEPTH));
  assign rd_valid = (fill != '0);
  assign push     = wr.valid && wr.ready;
  assign pop      = rd_valid && rd_ready;
  assign rd_data  = mem[rptr];

  // Next pointers and fill level
  always_comb begin
    next_wptr = push ? AW'(wptr + 1'b1) : wptr;
    next_rptr = pop  ? AW'(rptr + 1'b1) : rptr;
    next_fill = fill + (AW+1)'(push) - (AW+1)'(pop);
  end

  // Register pointers and write storage
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      wptr <= '0;
      rptr <= '0;
      fill <= '0;
    end else begin
      wptr <= next_wptr;
      rptr <= next_rptr;
      fill <= next_fill;
    end
    if (push) begin
      mem[wptr] <= wr.data;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/cfm_pair.sv ----
// Counter pair for frequency measurement: high-frequency, large-range and
// sample-clocked methods, results pushed into an 8-word FIFO.
// Assumes source, gate and sample clock pins are asynchronous and slower
// than half the 10 MHz system clock; each is synchronised before use.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Counters combine only in fixed pairs
// - High-frequency gate is known pulse, source unknown
// - Gate from partner counter or external terminal
// - High-frequency result is count N within T
// - Partner counter supplies fixed gating period
// - Primary makes pulse of N unknown periods
// - That pulse gates partner counting known timebase
// - Large-range result gives N and J
// - Divide-down N is an integer
// - Averaging select, defaults by operation type
// - Averaging counts unknown edges and timebase ticks
// - T1 and T2 latched at each sample clock
// - Non-averaging captures last complete period
// - Sample period is the measurement time
// - Pulse-width counts source only while gate active
// - Overrun when no full period between samples
module cfm_pair
  import cfm_pkg::*;
(
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst_b,
  // Pins (asynchronous)
  input  wire logic              unknown_pin,      // Signal under test
  input  wire logic              timebase_pin,     // Known timebase
  input  wire logic              ext_gate_pin,     // Known-width pulse on a terminal
  input  wire logic              sample_clk_pin,   // Sample clock
  // Configuration
  input  wire logic [1:0]        method,           // cfm_method_e
  input  wire logic              use_ext_gate,     // Gate from terminal, one counter
  input  wire logic [CNT_W-1:0]  gate_ticks,       // Partner gate width in timebase ticks
  input  wire logic [CNT_W-1:0]  divide_n,         // Integer divide-down N
  input  wire logic              hw_timed_single_sample, // Selects averaging default
  input  wire logic              avg_override,     // Use frequency_averaging_select
  input  wire logic              frequency_averaging_select,
  input  wire logic              arm,              // Start measurement, pulse
  input  wire logic              overflow_clear,   // Clears sticky overflow, pulse
  // Status
  output logic                   busy,
  output logic                   overflow,
  output logic                   partner_used,     // Second counter consumed
  // Results
  output logic                   res_valid,
  input  wire logic              res_ready,
  output logic [CNT_W-1:0]       res_primary,      // N or T2/period ticks
  output logic [CNT_W-1:0]       res_partner,      // Zero, J or T1
  output logic                   res_overflow
);
  // Synchronisers: first stage read only by second
  // The pins are asynchronous; s1 may go metastable, so only s2 reads it
  // s3 holds the previous s2 value for the edge detectors
  logic [3:0] s1, s2, s3;
  logic [3:0] pins;
  assign pins = {sample_clk_pin, ext_gate_pin, timebase_pin, unknown_pin};
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      s1 <= 4'h0;
      s2 <= 4'h0;
      s3 <= 4'h0;
    end else begin
      s1 <= pins;
      s2 <= s1;
      s3 <= s2;
    end
  end
  // Rising edges and external gate level after synchronisation
  // Detectors start from the idle low level, so reset gives no false edge
  logic ux_rise, tb_rise, eg_level, sc_rise;
  assign ux_rise  = s2[0] && !s3[0];
  assign tb_rise  = s2[1] && !s3[1];
  assign eg_level = s2[2];
  assign sc_rise  = s2[3] && !s3[3];

  // FIFO link
  // The counter pair writes its words here; the FIFO drains them to the ports
  cfm_fifo_if #(.WIDTH(RES_W)) fifo_in ();

  // Averaging choice: buffered defaults on, single-sample off
  // Override lets software force either behaviour in both operation types
  logic avg_on;
  assign avg_on = avg_override ? frequency_averaging_select
                               : !hw_timed_single_sample;

  // State
  // cnt_a is the primary counter, cnt_b the partner or embedded counter
  // The period tracker runs beside them for the non-averaging mode
  cfm_state_e state, next_state;
  logic [CNT_W-1:0] cnt_a, next_cnt_a;   // Primary counter
  logic [CNT_W-1:0] cnt_b, next_cnt_b;   // Partner / embedded counter
  logic [CNT_W-1:0] gate_cnt, next_gate_cnt; // Partner gate generator
  logic [CNT_W-1:0] per_cnt, next_per_cnt;   // Running period ticks
  logic [CNT_W-1:0] last_per, next_last_per; // Last complete period
  logic             per_seen, next_per_seen; // A full period ended since sample
  logic             per_run, next_per_run;   // A period is in progress
  logic             pend, next_pend;         // Result waiting for FIFO
  logic [RES_W-1:0] pend_w, next_pend_w;
  logic             sticky, next_sticky;
  logic             eg_prev, next_eg_prev;   // Previous external gate level
  logic             sc_seen, next_sc_seen;   // Sample clock flag; cleared on arm, never set

  // Next-state logic of the pair
  always_comb begin
    next_state    = state;
    next_cnt_a    = cnt_a;
    next_cnt_b    = cnt_b;
    next_gate_cnt = gate_cnt;
    next_per_cnt  = per_cnt;
    next_last_per = last_per;
    next_per_seen = per_seen;
    next_per_run  = per_run;
    next_pend     = pend;
    next_pend_w   = pend_w;
    // Clear first; any set below overrides it, so an event in the same
    // cycle as the clear still leaves the flag raised
    next_sticky   = sticky && !overflow_clear;
    next_eg_prev  = eg_level;
    next_sc_seen  = sc_seen;
    // Hand the pending word to the FIFO
    if (pend && fifo_in.ready) begin
      next_pend = 1'b0;
    end
    case (state)
      CFM_IDLE: begin
        if (arm) begin
          next_cnt_a    = CNT_ZERO;
          next_cnt_b    = CNT_ZERO;
          next_gate_cnt = CNT_ZERO;
          next_per_cnt  = CNT_ZERO;
          next_per_seen = 1'b0;
          next_per_run  = 1'b0;
          next_sc_seen  = 1'b0;
          next_state    = CFM_WAIT_START;
        end
      end
      CFM_WAIT_START: begin
        case (method)
          CFM_HIGH_FREQ: begin
            // External gate starts on its rising edge; partner starts at once
            if (!use_ext_gate || (eg_level && !eg_prev)) begin
              next_state = CFM_MEASURE;
            end
          end
          CFM_LARGE_RANGE: begin
            // Divided pulse opens on the first unknown edge
            if (ux_rise) begin
              next_state = CFM_MEASURE;
            end
          end
          CFM_SAMPLE_CLOCKED: begin
            if (sc_rise) begin
              next_state = CFM_MEASURE;
            end
          end
          default: next_state = CFM_IDLE;
        endcase
      end
      CFM_MEASURE: begin
        case (method)
          CFM_HIGH_FREQ: begin
            // Gate active: count unknown edges as N within T
            if (ux_rise) begin
              next_cnt_a = cnt_a + CNT_ONE;
              if (cnt_a == CNT_MAX) next_sticky = 1'b1;
            end
            if (use_ext_gate) begin
              if (!eg_level) next_state = CFM_DONE;
            end else begin
              // Partner counts a fixed number of timebase ticks
              // A gate_ticks of zero ends the gate after one cycle, counting at most one unknown edge
              // The gate length is fixed, so the measurement time is known
              if (tb_rise) next_gate_cnt = gate_cnt + CNT_ONE;
              if (gate_cnt >= gate_ticks) next_state = CFM_DONE;
            end
          end
          CFM_LARGE_RANGE: begin
            // Primary counts N unknown periods; its pulse gates partner
            // The opening unknown edge is not counted, so exactly N periods pass
            if (ux_rise) begin
              next_cnt_a = cnt_a + CNT_ONE;
              if (cnt_a + CNT_ONE >= divide_n) next_state = CFM_DONE;
            end
            if (tb_rise) begin
              next_cnt_b = cnt_b + CNT_ONE;
              if (cnt_b == CNT_MAX) next_sticky = 1'b1;
            end
          end
          CFM_SAMPLE_CLOCKED: begin
            // Period tracker for non-averaging mode
            if (tb_rise) next_per_cnt = per_cnt + CNT_ONE;
            if (ux_rise) begin
              if (per_run) begin
                next_last_per = per_cnt + (tb_rise ? CNT_ONE : CNT_ZERO);
                next_per_seen = 1'b1;
              end
              next_per_run = 1'b1;
              next_per_cnt = CNT_ZERO;
            end
            // Averaging counts: embedded = unknown, primary = timebase
            if (ux_rise) next_cnt_b = cnt_b + CNT_ONE;
            if (tb_rise) next_cnt_a = cnt_a + CNT_ONE;
            if (sc_rise) begin
              // Latch per-sample counts and restart the window
              // A word still waiting for a full FIFO is overwritten here;
              // the overflow flag reports the loss
              next_pend = 1'b1;
              if (avg_on) begin
                next_pend_w = {!per_seen, cnt_a, cnt_b};
              end else begin
                next_pend_w = {!per_seen, last_per, CNT_ONE};
              end
              if (!per_seen || (pend && !fifo_in.ready)) next_sticky = 1'b1;
              next_cnt_a    = CNT_ZERO;
              next_cnt_b    = CNT_ZERO;
              next_per_seen = 1'b0;
            end
            if (arm) next_state = CFM_IDLE;
          end
          default: next_state = CFM_IDLE;
        endcase
      end
      CFM_DONE: begin
        // One-shot methods hand one result pair
        // Waits here while an earlier word still holds the pending slot
        if (!pend) begin
          next_pend   = 1'b1;
          next_pend_w = {1'b0, cnt_a, cnt_b};
          next_state  = CFM_IDLE;
        end
      end
      default: next_state = CFM_IDLE;
    endcase
  end

  // Register the pair state
  // Every register resets to a constant; no reset path reads logic
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state    <= CFM_IDLE;
      cnt_a    <= CNT_ZERO;
      cnt_b    <= CNT_ZERO;
      gate_cnt <= CNT_ZERO;
      per_cnt  <= CNT_ZERO;
      last_per <= CNT_ZERO;
      per_seen <= 1'b0;
      per_run  <= 1'b0;
      pend     <= 1'b0;
      pend_w   <= '0;
      sticky   <= 1'b0;
      eg_prev  <= 1'b0;
      sc_seen  <= 1'b0;
    end else begin
      state    <= next_state;
      cnt_a    <= next_cnt_a;
      cnt_b    <= next_cnt_b;
      gate_cnt <= next_gate_cnt;
      per_cnt  <= next_per_cnt;
      last_per <= next_last_per;
      per_seen <= next_per_seen;
      per_run  <= next_per_run;
      pend     <= next_pend;
      pend_w   <= next_pend_w;
      sticky   <= next_sticky;
      eg_prev  <= next_eg_prev;
      sc_seen  <= next_sc_seen;
    end
  end

  // Pending word feeds the FIFO
  assign fifo_in.valid = pend;
  assign fifo_in.data  = pend_w;

  // Fixed pairing: this module is one pair, primary plus partner
  assign partner_used = (method != CFM_HIGH_FREQ) || !use_ext_gate;
  assign busy         = (state != CFM_IDLE);
  assign overflow     = sticky;

  // Result FIFO: eight words of count pair plus overflow flag
  logic [RES_W-1:0] rd_word;
  cfm_fifo #(.WIDTH(RES_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .wr       (fifo_in),
    .rd_valid (res_valid),
    .rd_ready (res_ready),
    .rd_data  (rd_word)
  );
  // Unpack the head word into the result ports
  assign res_overflow = rd_word[RES_W-1];
  assign res_primary  = rd_word[2*CNT_W-1:CNT_W];
  assign res_partner  = rd_word[CNT_W-1:0];
endmodule
`default_nettype wire

// ---- verification/cfm_checker.sv ----
// Concurrent checks on the counter pair top-level ports.
// Assumes one clock domain, sys_clk, and synchronous active-low rst_b.
`timescale 1ns/1ps
`default_nettype none
module cfm_checker
  import cfm_pkg::*;
(
  // Clock and reset
  input wire logic             sys_clk,
  input wire logic             rst_b,
  // Configuration
  input wire logic [1:0]       method,
  input wire logic             use_ext_gate,
  input wire logic [CNT_W-1:0] divide_n,
  input wire logic             hw_timed_single_sample,
  input wire logic             avg_override,
  input wire logic             arm,
  // Status and results
  input wire logic             busy,
  input wire logic             overflow,
  input wire logic             overflow_clear,
  input wire logic             partner_used,
  input wire logic             res_valid,
  input wire logic             res_ready,
  input wire logic [CNT_W-1:0] res_primary,
  input wire logic [CNT_W-1:0] res_partner,
  input wire logic             res_overflow
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // A one-shot measurement ends when busy drops
  sequence s_oneshot_end;
    $fell(busy) && method != CFM_SAMPLE_CLOCKED;
  endsequence
  reset_idle_a: assert property (disable iff (1'b0) !rst_b |=> !busy && !overflow && !res_valid)
    else $error("outputs not idle after reset");
  arm_take_a: assert property (!busy && arm |=> busy)
    else $error("arm in idle not taken");
  head_hold_a: assert property (res_valid && !res_ready |=> res_valid && $stable(res_primary)
    && $stable(res_partner) && $stable(res_overflow))
    else $error("result head changed before pop");
  ovf_sticky_a: assert property (overflow && !overflow_clear |=> overflow)
    else $error("overflow lost without clear");
  ext_single_a: assert property (method == CFM_HIGH_FREQ && use_ext_gate |-> !partner_used)
    else $error("partner consumed with external gate");
  pair_used_a: assert property (method == CFM_LARGE_RANGE |-> partner_used)
    else $error("large range without partner");
  hf_zero_a: assert property (res_valid && method == CFM_HIGH_FREQ |-> res_partner == CNT_ZERO)
    else $error("high frequency partner word not zero");
  lr_count_a: assert property (res_valid && method == CFM_LARGE_RANGE |-> res_primary == divide_n)
    else $error("large range N differs from divide_n");
  nonavg_one_a: assert property (res_valid && method == CFM_SAMPLE_CLOCKED && !avg_override
    && hw_timed_single_sample && !res_overflow |-> res_partner == CNT_ONE)
    else $error("single period result not one period");
  done_push_a: assert property (s_oneshot_end |-> ##[0:4] res_valid)
    else $error("result not pushed after measurement");
endmodule
bind cfm_pair cfm_checker i_chk (.sys_clk(sys_clk), .rst_b(rst_b), .method(method),
  .use_ext_gate(use_ext_gate), .divide_n(divide_n), .hw_timed_single_sample(hw_timed_single_sample),
  .avg_override(avg_override), .arm(arm), .busy(busy), .overflow(overflow),
  .overflow_clear(overflow_clear), .partner_used(partner_used), .res_valid(res_valid),
  .res_ready(res_ready), .res_primary(res_primary), .res_partner(res_partner),
  .res_overflow(res_overflow));
`default_nettype wire

// ---- verification/cfm_src_model.sv ----
// Far-side sources: signal under test, timebase, gate pulse, sample clock.
// Assumes sys_clk; pins move after rising edges, so all share one phase.
`timescale 1ns/1ps
`default_nettype none
module cfm_src_model (
  // Clock and control from the bench
  input  wire logic sys_clk,
  input  wire logic unk_en,
  input  wire logic smp_en,
  input  wire logic gate_go,
  input  wire logic [31:0] gate_len,
  // Pins
  output logic      unknown_pin,
  output logic      timebase_pin,
  output logic      ext_gate_pin,
  output logic      sample_clk_pin
);
  int   cyc  = 0; // Free cycle count
  int   glen = 0; // Gate cycles left
  logic pend = 1'b0;
  initial begin
    unknown_pin = 1'b0;
    timebase_pin = 1'b0;
    ext_gate_pin = 1'b0;
    sample_clk_pin = 1'b0;
  end
  // Unknown period 8, timebase 4, sample clock 64 cycles: fx well above 2 fs
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    unknown_pin <= unk_en && (cyc % 8) >= 4;
    timebase_pin <= (cyc % 4) >= 2;
    sample_clk_pin <= smp_en && (cyc % 64) < 4;
    // Gate opens away from unknown edges and spans gate_len unknown periods
    if (gate_go) pend <= 1'b1;
    if (pend && (cyc % 8) == 1) begin
      pend <= 1'b0;
      ext_gate_pin <= 1'b1;
      glen <= gate_len * 8;
    end else if (glen == 1) begin
      glen <= 0;
      ext_gate_pin <= 1'b0;
    end else if (glen > 1) glen <= glen - 1;
  end
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
// Self-checking bench for the counter pair with its source model.
// Assumes a 100 ns sys_clk; inputs change at the falling edge.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD %s exp %0h got %0h", n, e, g); end end
module testbench;
  import cfm_pkg::*;
  logic sys_clk = 0, rst_b = 0, arm = 0, overflow_clear = 0, res_ready = 0;
  logic [1:0] method = 2'h0;
  logic use_ext_gate = 0, hw_ts = 0, avg_ovr = 0, avg_sel = 0;
  logic [CNT_W-1:0] gate_ticks = 32'h0000_0008, divide_n = 32'h0000_0001;
  logic unk_en = 1, smp_en = 0, gate_go = 0;
  int gate_len = 1;
  wire logic unk, tb, gate, smp;
  logic busy, overflow, partner_used, res_valid, res_overflow;
  logic [CNT_W-1:0] res_primary, res_partner;
  int mismatches = 0, compares = 0, n, k;
  cfm_src_model i_src (.sys_clk(sys_clk), .unk_en(unk_en), .smp_en(smp_en), .gate_go(gate_go),
    .gate_len(gate_len), .unknown_pin(unk), .timebase_pin(tb), .ext_gate_pin(gate),
    .sample_clk_pin(smp));
  cfm_pair i_dut (.sys_clk(sys_clk), .rst_b(rst_b), .unknown_pin(unk), .timebase_pin(tb),
    .ext_gate_pin(gate), .sample_clk_pin(smp), .method(method), .use_ext_gate(use_ext_gate),
    .gate_ticks(gate_ticks), .divide_n(divide_n), .hw_timed_single_sample(hw_ts),
    .avg_override(avg_ovr), .frequency_averaging_select(avg_sel), .arm(arm),
    .overflow_clear(overflow_clear), .busy(busy), .overflow(overflow),
    .partner_used(partner_used), .res_valid(res_valid), .res_ready(res_ready),
    .res_primary(res_primary), .res_partner(res_partner), .res_overflow(res_overflow));
  // 10 MHz clock
  initial forever #50 sys_clk = ~sys_clk;
  task automatic test_done;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic pulse_arm;
    arm = 1;
    @(negedge sys_clk) arm = 0;
  endtask
  // Wait for a result, compare it with the expected ranges, then pop it
  task automatic pop(input logic [31:0] plo, phi, rlo, rhi, input logic ovf);
    int w;
    w = 0;
    while (res_valid !== 1'b1 && w < 2000) begin @(negedge sys_clk); w++; end
    `CHK("res_valid", 1'b1, res_valid)
    `CHK("res_primary", 1'b1, res_primary >= plo && res_primary <= phi)
    `CHK("res_partner", 1'b1, res_partner >= rlo && res_partner <= rhi)
    `CHK("res_overflow", ovf, res_overflow)
    res_ready = 1;
    @(negedge sys_clk) res_ready = 0;
  endtask
  // Stop sample mode and throw away what is left
  task automatic stop_flush;
    pulse_arm();
    repeat (300) @(negedge sys_clk) res_ready = res_valid;
    res_ready = 0;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    test_done();
  end
  initial begin
    void'($urandom(17937));
    repeat (16) @(negedge sys_clk);
    rst_b = 1;
    // High frequency, external gate; a second arm mid-run is ignored
    use_ext_gate = 1;
    for (int i = 0; i < 3; i++) begin
      gate_len = 1 + $urandom % 5;
      pulse_arm();
      repeat (4) @(negedge sys_clk);
      gate_go = 1;
      @(negedge sys_clk) gate_go = 0;
      pulse_arm();
      pop(gate_len, gate_len, 0, 0, 0);
      `CHK("partner_used", 1'b0, partner_used)
    end
    // High frequency, partner makes an 8-tick gate: 32 cycles hold 4 periods
    use_ext_gate = 0;
    pulse_arm();
    pop(3, 5, 0, 0, 0);
    `CHK("partner_used", 1'b1, partner_used)
    // Large range: pulse of N periods timed by a timebase twice as fast
    method = 2'h1;
    for (int i = 0; i < 3; i++) begin
      n = 1 + $urandom % 6;
      divide_n = n;
      pulse_arm();
      pop(n, n, 2 * n - 1, 2 * n + 1, 0);
    end
    // Sample clocked: defaults and override of the averaging select
    method = 2'h2;
    smp_en = 1;
    for (int m = 0; m < 4; m++) begin
      avg_ovr = m[1];
      avg_sel = m[0];
      hw_ts = m[0];
      pulse_arm();
      repeat (3) begin
        if (m == 0 || m == 3) pop(15, 17, 7, 9, 0);
        else pop(1, 3, 1, 1, 0);
      end
      stop_flush();
    end
    // No signal under test: every sample overruns
    unk_en = 0;
    pulse_arm();
    pop(0, CNT_MAX, 0, CNT_MAX, 1);
    `CHK("overflow", 1'b1, overflow)
    stop_flush();
    unk_en = 1;
    overflow_clear = 1;
    @(negedge sys_clk) overflow_clear = 0;
    `CHK("overflow", 1'b0, overflow)
    // Fill the FIFO without draining until a pending word is overwritten
    pulse_arm();
    repeat (64 * 12) @(negedge sys_clk);
    `CHK("overflow", 1'b1, overflow)
    pulse_arm();
    k = 0;
    while (res_valid === 1'b1 && k < 20) begin res_ready = 1; @(negedge sys_clk); k++; end
    res_ready = 0;
    `CHK("fifo_words", 1'b1, k >= FIFO_DEPTH && k <= FIFO_DEPTH + 1)
    `CHK("res_valid", 1'b0, res_valid)
    test_done();
  end
endmodule
`default_nettype wire
